// ### core/tas_regs.svh
// register offsets, field positions and reset values of the temperature alarm register bank
// Notes on behaviour
// - configuration bit 7 set halts conversions and holds standby until cleared.
// - writing one to configuration bit 6 resets every register, then clears itself.
// - configuration bit 5 zero enables the serial bus timeout, one disables it.
// - configuration bit 1 one selects -64 to +191 C, zero selects 0 to +255 C.
// - alert mask: bit 7 remote 7, bit 6 local, bits 5..0 remote 6..1.
// - overtemp mask: bit 7 local, bits 6..0 remote 7..1; one suppresses output.
// - high alert status: bit 7 remote 7, bit 6 local, bits 5..0 remote 6..1.
// - overtemperature status flags report a channel above its overtemperature limit.
// - diode fault status flags report open or shorted remote sensing diodes.
// - low alert status flags report a channel below its low alert limit.
// - alert status bits clear on a completed read, set again at next conversion.
// - alert follows flags; clears on high status read or alert response completion.
// - alert clears even with fault present, reasserts after next conversion.
// - overtemp flags hold until temperature below limit minus 4 C or limit raised.
// - with standby bit zero the device converts continuously.
// - alerting device answers response address 19h with its own address, then clears.
// - the 8-bit command byte selects the register for following reads and writes.
`ifndef TAS_REGS_SVH
`define TAS_REGS_SVH

`define TAS_OFS_CFG         8'h41
`define TAS_OFS_ALERT_MASK  8'h42
`define TAS_OFS_OVERT_MASK  8'h43
`define TAS_OFS_HIGH_STAT   8'h44
`define TAS_OFS_OVERT_STAT  8'h45
`define TAS_OFS_FAULT_STAT  8'h46
`define TAS_OFS_LOW_STAT    8'h47

`define TAS_CFG_STANDBY_BIT 7
`define TAS_CFG_SOFTRST_BIT 6
`define TAS_CFG_TODIS_BIT   5
`define TAS_CFG_WIDE_BIT    1
`define TAS_CFG_KEEP_MASK   8'ha2

`define TAS_RST_CFG         8'h00
`define TAS_RST_MASK        8'h00
`define TAS_RST_STAT        8'h00
`define TAS_RST_PTR         8'h00

`define TAS_ARA_BYTE        8'h19
`define TAS_BYTE_BITS       4'h8

`endif

// ### core/tas_pkg.sv
// types shared by the temperature alarm register bank
package tas_pkg;

	typedef enum logic [3:0] {
		TAS_IDLE      = 4'b0000,
		TAS_ADDR      = 4'b0001,
		TAS_ACK_ADDR  = 4'b0010,
		TAS_CMD       = 4'b0011,
		TAS_ACK_CMD   = 4'b0100,
		TAS_WDATA     = 4'b0101,
		TAS_ACK_WDATA = 4'b0110,
		TAS_TX        = 4'b0111,
		TAS_TX_ACK    = 4'b1000
	} tas_state_t;

	// results of one finished conversion round, in status register bit order
	typedef struct packed {
		logic       done;
		logic [7:0] high;
		logic [7:0] low;
		logic [7:0] over;
		logic [7:0] release_ok;
		logic [6:0] fault;
	} tas_conv_t;

	typedef struct packed {
		logic standby;
		logic run;
		logic wide_range_select;
		logic timeout_en;
	} tas_ctrl_t;

endpackage

// ### core/tas_bank.sv
// serial register bank with alert and overtemperature outputs of the temperature monitor
`timescale 1ns/1ps
`include "tas_regs.svh"

module tas_bank
	import tas_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = 7'h2a  // arbitrary default, set per board
)
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// serial link pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// conversion engine
	input  wire tas_conv_t  conv,
	output tas_ctrl_t       ctrl,
	// open-drain alarm pins, enable high pulls the line low
	output logic            alert_oe,
	output logic            overt_oe
);

	logic [1:0]  scl_sync;
	logic [1:0]  sda_sync;
	logic        scl_d;
	logic        sda_d;
	logic        scl_rise;
	logic        scl_fall;
	logic        bus_start;
	logic        bus_stop;
	tas_state_t  state;
	logic [3:0]  cnt;
	logic [7:0]  sh;
	logic [7:0]  tx;
	logic        is_ara;
	logic        is_read;
	logic        cmd_stb;
	logic        wr_stb;
	logic        rd_stb;
	logic        ara_done;
	logic        soft_rst;
	logic        reg_rst;
	logic [7:0]  ptr;
	logic [7:0]  cfg;
	logic [7:0]  alert_mask;
	logic [7:0]  overt_mask;
	logic [7:0]  high_stat;
	logic [7:0]  low_stat;
	logic [7:0]  overt_stat;
	logic [7:0]  fault_stat;
	logic        alert_lat;
	logic [7:0]  rd_data;
	logic        conv_ok;
	logic [7:0]  next_high;
	logic [7:0]  next_low;
	logic [7:0]  next_overt;
	logic        next_alert;

	// pin synchronisers; the first stage feeds only the second
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
		end
		else
		begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_d    <= scl_sync[1];
			sda_d    <= sda_sync[1];
		end
	end

	assign scl_rise  = scl_sync[1] & ~scl_d;
	assign scl_fall  = ~scl_sync[1] & scl_d;
	assign bus_start = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
	assign bus_stop  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
	assign sda_out   = 1'b0;

	// serial slave: bits taken on scl rise, driven on scl fall
	always_ff @(posedge mclk)
	begin
		cmd_stb  <= 1'b0;
		wr_stb   <= 1'b0;
		rd_stb   <= 1'b0;
		ara_done <= 1'b0;
		if (rst)
		begin
			state   <= TAS_IDLE;
			cnt     <= 4'h0;
			sh      <= 8'h00;
			tx      <= 8'h00;
			is_ara  <= 1'b0;
			is_read <= 1'b0;
			sda_oe  <= 1'b0;
		end
		else if (bus_start)
		begin
			state  <= TAS_ADDR;
			cnt    <= 4'h0;
			sda_oe <= 1'b0;
		end
		else if (bus_stop)
		begin
			state  <= TAS_IDLE;
			sda_oe <= 1'b0;
		end
		else
		begin
			case (state)
				TAS_ADDR, TAS_CMD, TAS_WDATA:
				begin
					if (scl_rise)
					begin
						sh  <= {sh[6:0], sda_sync[1]};
						cnt <= cnt + 4'h1;
					end
					else if (scl_fall && cnt == `TAS_BYTE_BITS)
					begin
						cnt <= 4'h0;
						if (state == TAS_ADDR)
						begin
							is_read <= sh[0];
							is_ara  <= 1'b0;
							if (sh[7:1] == SLAVE_ADDR)
							begin
								sda_oe <= 1'b1;
								state  <= TAS_ACK_ADDR;
							end
							else if (sh == `TAS_ARA_BYTE && alert_oe)
							begin
								is_ara <= 1'b1;
								sda_oe <= 1'b1;
								state  <= TAS_ACK_ADDR;
							end
							else
								state <= TAS_IDLE;
						end
						else if (state == TAS_CMD)
						begin
							cmd_stb <= 1'b1;
							sda_oe  <= 1'b1;
							state   <= TAS_ACK_CMD;
						end
						else
						begin
							wr_stb <= 1'b1;
							sda_oe <= 1'b1;
							state  <= TAS_ACK_WDATA;
						end
					end
				end
				TAS_ACK_ADDR:
				begin
					if (scl_fall)
					begin
						if (is_read)
						begin
							tx     <= is_ara ? {SLAVE_ADDR, 1'b0} : rd_data;
							sda_oe <= is_ara ? ~SLAVE_ADDR[6] : ~rd_data[7];
							state  <= TAS_TX;
						end
						else
						begin
							sda_oe <= 1'b0;
							state  <= TAS_CMD;
						end
					end
				end
				TAS_ACK_CMD, TAS_ACK_WDATA:
				begin
					if (scl_fall)
					begin
						sda_oe <= 1'b0;
						state  <= TAS_WDATA;
					end
				end
				TAS_TX:
				begin
					if (scl_rise)
					begin
						cnt <= cnt + 4'h1;
						// a released one seen low means another responder won
						if (!sda_oe && !sda_sync[1])
							state <= TAS_IDLE;
					end
					else if (scl_fall)
					begin
						if (cnt == `TAS_BYTE_BITS)
						begin
							sda_oe <= 1'b0;
							state  <= TAS_TX_ACK;
						end
						else
						begin
							tx     <= {tx[6:0], 1'b0};
							sda_oe <= ~tx[6];
						end
					end
				end
				TAS_TX_ACK:
				begin
					if (scl_rise)
					begin
						cnt <= 4'h0;
						if (is_ara)
							ara_done <= 1'b1;
						else
							rd_stb <= 1'b1;
						if (sda_sync[1])
							state <= TAS_IDLE;
					end
					else if (scl_fall)
					begin
						tx     <= rd_data;
						sda_oe <= ~rd_data[7];
						state  <= TAS_TX;
					end
				end
				default:
				begin
					state  <= TAS_IDLE;
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

	assign reg_rst = rst | soft_rst;
	// self-clearing reset bit: one cycle of bank reset, never read back as one
	always_ff @(posedge mclk)
	begin
		if (rst)
			soft_rst <= 1'b0;
		else
			soft_rst <= wr_stb && ptr == `TAS_OFS_CFG && sh[`TAS_CFG_SOFTRST_BIT];
	end

	always_ff @(posedge mclk)
	begin
		if (reg_rst)
			ptr <= `TAS_RST_PTR;
		else if (cmd_stb)
			ptr <= sh;
	end

	always_ff @(posedge mclk)
	begin
		if (reg_rst)
		begin
			cfg        <= `TAS_RST_CFG;
			alert_mask <= `TAS_RST_MASK;
			overt_mask <= `TAS_RST_MASK;
		end
		else if (wr_stb)
		begin
			case (ptr)
				// reserved bits are dropped even if the host breaks the zero convention
				`TAS_OFS_CFG:        cfg <= sh & `TAS_CFG_KEEP_MASK;
				`TAS_OFS_ALERT_MASK: alert_mask <= sh;
				`TAS_OFS_OVERT_MASK: overt_mask <= sh;
				default:             cfg <= cfg;
			endcase
		end
	end

	assign ctrl.standby           = cfg[`TAS_CFG_STANDBY_BIT];
	assign ctrl.run               = ~cfg[`TAS_CFG_STANDBY_BIT];
	assign ctrl.timeout_en        = ~cfg[`TAS_CFG_TODIS_BIT];
	assign ctrl.wide_range_select = cfg[`TAS_CFG_WIDE_BIT];

	// results that arrive in standby are stale and dropped
	assign conv_ok = conv.done & ~cfg[`TAS_CFG_STANDBY_BIT];

	// a flag set in the cycle of its read-clear survives
	always_comb
	begin
		next_high  = high_stat & ~{8{rd_stb && ptr == `TAS_OFS_HIGH_STAT}};
		next_low   = low_stat & ~{8{rd_stb && ptr == `TAS_OFS_LOW_STAT}};
		next_overt = overt_stat;
		next_alert = alert_lat & ~((rd_stb && ptr == `TAS_OFS_HIGH_STAT) | ara_done);
		if (conv_ok)
		begin
			next_high  = next_high | conv.high;
			next_low   = next_low | conv.low;
			next_overt = (overt_stat & ~conv.release_ok) | conv.over;
			if (|((conv.high | conv.low) & ~alert_mask))
				next_alert = 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reg_rst)
		begin
			high_stat  <= `TAS_RST_STAT;
			low_stat   <= `TAS_RST_STAT;
			overt_stat <= `TAS_RST_STAT;
			alert_lat  <= 1'b0;
			fault_stat <= `TAS_RST_STAT;
			alert_oe   <= 1'b0;
			overt_oe   <= 1'b0;
		end
		else
		begin
			high_stat  <= next_high;
			low_stat   <= next_low;
			overt_stat <= next_overt;
			alert_lat  <= next_alert;
			// fault flags mirror the latest round; bit 7 has no channel
			fault_stat <= conv_ok ? {1'b0, conv.fault} : fault_stat;
			alert_oe   <= next_alert & |((next_high | next_low) & ~alert_mask);
			overt_oe   <= |(next_overt & ~overt_mask);
		end
	end

	always_comb
	begin
		case (ptr)
			`TAS_OFS_CFG:        rd_data = cfg;
			`TAS_OFS_ALERT_MASK: rd_data = alert_mask;
			`TAS_OFS_OVERT_MASK: rd_data = overt_mask;
			`TAS_OFS_HIGH_STAT:  rd_data = high_stat;
			`TAS_OFS_OVERT_STAT: rd_data = overt_stat;
			`TAS_OFS_FAULT_STAT: rd_data = fault_stat;
			`TAS_OFS_LOW_STAT:   rd_data = low_stat;
			default:             rd_data = 8'h00;
		endcase
	end

endmodule

// ### tb/tas_host.sv
// serial host model that frames starts, stops and bytes on the register link
`timescale 1ns/1ps
module tas_host (
	// clock and returned data level
	input  wire logic mclk,
	input  wire logic sda,
	// driven pins, pull high means the data line is held low
	output logic      scl,
	output logic      m_pull
);
	initial
	begin
		scl = 1'b1;
		m_pull = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// the clock only moves inside frames, data set while it is low
	task automatic bitx(input logic b, output logic r);
		m_pull <= !b;
		wt(4);
		scl <= 1'b1;
		wt(2);
		@(negedge mclk);
		r = sda;
		wt(2);
		scl <= 1'b0;
	endtask
	task automatic start();
		wt(1);
		m_pull <= 1'b0;
		wt(4);
		scl <= 1'b1;
		wt(4);
		m_pull <= 1'b1;
		wt(4);
		scl <= 1'b0;
	endtask
	task automatic stop();
		m_pull <= 1'b1;
		wt(4);
		scl <= 1'b1;
		wt(4);
		m_pull <= 1'b0;
		wt(4);
	endtask
	// msb first, ninth bit is b9 from us and as seen on the wire
	task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q,
		output logic r9);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(b9, r9);
	endtask
endmodule

// ### tb/tas_bank_asserts.sv
// port checker for the register bank and its alarm outputs
`timescale 1ns/1ps
module tas_bank_asserts
	import tas_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      rst,
	input  wire logic      scl_in,
	input  wire logic      sda_out,
	input  wire logic      sda_oe,
	input  wire tas_conv_t conv,
	input  wire tas_ctrl_t ctrl,
	input  wire logic      alert_oe,
	input  wire logic      overt_oe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence scl_up;
		$rose(scl_in);
	endsequence
	reset_vals_a: assert property ($fell(rst) |-> !alert_oe && !overt_oe && !sda_oe
		&& ctrl.run && ctrl.timeout_en && !ctrl.wide_range_select) else $error("bad reset");
	ctrl_mode_a: assert property (ctrl.run == !ctrl.standby) else $error("run mode");
	standby_hold_a: assert property (ctrl.standby && !alert_oe |=> !alert_oe)
		else $error("alert in standby");
	alert_rise_a: assert property ($rose(alert_oe) |-> $past(conv.done))
		else $error("alert without round");
	overt_rise_a: assert property ($rose(overt_oe) |-> $past(conv.done))
		else $error("overt without round");
	sda_low_a: assert property (sda_out == 1'b0) else $error("data not open drain");
	ack_low_a: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
		else $error("data moved with clock high");
	bit_stand_a: assert property (scl_up |=> $stable(sda_oe)[*3])
		else $error("bit not held");
endmodule
bind tas_bank tas_bank_asserts tas_bank_asserts_inst (.mclk(mclk), .rst(rst),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .conv(conv), .ctrl(ctrl),
	.alert_oe(alert_oe), .overt_oe(overt_oe));

// ### tb/tas_bank_bench.sv
// register, alarm and response-address tests of the register bank
`timescale 1ns/1ps
module tas_bank_bench;
	import tas_pkg::*;
	localparam logic [6:0] SA = 7'h2a; // arbitrary bus address
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic scl, m_pull, sda_out, sda_oe, alert_oe, overt_oe, a;
	logic [7:0] q;
	tas_conv_t conv = '0;
	tas_ctrl_t ctrl;
	wire logic sda = !(sda_oe | m_pull);
	int mismatches = 0;
	int check_count = 0;
	always #20 mclk = !mclk;
	tas_host tas_host_inst (.mclk(mclk), .sda(sda), .scl(scl), .m_pull(m_pull));
	tas_bank #(.SLAVE_ADDR(SA)) tas_bank_inst (.mclk(mclk), .rst(rst), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .conv(conv), .ctrl(ctrl),
		.alert_oe(alert_oe), .overt_oe(overt_oe));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] v);
		tas_host_inst.start();
		tas_host_inst.xfer({SA, 1'b0}, 1'b1, q, a);
		tas_host_inst.xfer(c, 1'b1, q, a);
		tas_host_inst.xfer(v, 1'b1, q, a);
		tas_host_inst.stop();
	endtask
	task automatic rd(input logic [7:0] c, input logic [7:0] e);
		tas_host_inst.start();
		tas_host_inst.xfer({SA, 1'b0}, 1'b1, q, a);
		tas_host_inst.xfer(c, 1'b1, q, a);
		tas_host_inst.start();
		tas_host_inst.xfer({SA, 1'b1}, 1'b1, q, a);
		tas_host_inst.xfer(8'hff, 1'b1, q, a);
		tas_host_inst.stop();
		chk(q, e);
	endtask
	// one finished conversion round, outputs looked at once they settle
	task automatic rnd(input logic [7:0] h, l, o, r, input logic [6:0] f);
		@(posedge mclk);
		conv <= {1'b1, h, l, o, r, f};
		@(posedge mclk);
		conv.done <= 1'b0;
		repeat (2) @(negedge mclk);
	endtask
	task automatic pins(input logic al, ov);
		chk({6'h00, alert_oe, overt_oe}, {6'h00, al, ov});
	endtask
	task automatic conclude();
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		rd(8'h41, 8'h00);
		rd(8'h42, 8'h00);
		rd(8'h43, 8'h00);
		rd(8'h44, 8'h00);
		rd(8'h50, 8'h00);
		$display("test 1 done");
		wr(8'h41, 8'ha2);
		rd(8'h41, 8'ha2);
		chk({4'h0, ctrl}, 8'h0a);
		rnd(8'hff, 8'h00, 8'h00, 8'h00, 7'h00);
		pins(1'b0, 1'b0);
		wr(8'h41, 8'h00);
		chk({4'h0, ctrl}, 8'h05);
		$display("test 2 done");
		wr(8'h42, 8'h40);
		rnd(8'h40, 8'h00, 8'h00, 8'h00, 7'h00);
		pins(1'b0, 1'b0);
		rd(8'h44, 8'h40);
		rd(8'h44, 8'h00);
		rnd(8'h80, 8'h00, 8'h00, 8'h00, 7'h00);
		pins(1'b1, 1'b0);
		rd(8'h44, 8'h80);
		pins(1'b0, 1'b0);
		rnd(8'h80, 8'h00, 8'h00, 8'h00, 7'h00);
		pins(1'b1, 1'b0);
		tas_host_inst.start();
		tas_host_inst.xfer(8'h19, 1'b1, q, a);
		chk({7'h00, a}, 8'h00);
		tas_host_inst.xfer(8'hff, 1'b1, q, a);
		tas_host_inst.stop();
		chk(q, {SA, 1'b0});
		pins(1'b0, 1'b0);
		$display("test 3 done");
		wr(8'h43, 8'h80);
		rnd(8'h00, 8'h00, 8'h80, 8'h00, 7'h00);
		pins(1'b0, 1'b0);
		rnd(8'h00, 8'h00, 8'h40, 8'h00, 7'h05);
		pins(1'b0, 1'b1);
		rd(8'h45, 8'hc0);
		rd(8'h46, 8'h05);
		rnd(8'h00, 8'h02, 8'h00, 8'h00, 7'h05);
		pins(1'b1, 1'b1);
		rnd(8'h00, 8'h00, 8'h00, 8'hff, 7'h05);
		pins(1'b1, 1'b0);
		rd(8'h47, 8'h02);
		rd(8'h47, 8'h00);
		$display("test 4 done");
		wr(8'h42, 8'h5a);
		wr(8'h41, 8'h40);
		rd(8'h41, 8'h00);
		rd(8'h42, 8'h00);
		tas_host_inst.start();
		tas_host_inst.xfer(8'h19, 1'b1, q, a);
		tas_host_inst.stop();
		chk({7'h00, a}, 8'h01);
		$display("test 5 done");
		conclude();
	end
endmodule
